// ==== hw/startup_cfg_pkg.sv ====
// constants, field layout and decode tables for the start-up configuration block
// assumes a single 125 MHz clock domain and a simple word-wide register port
// ****************************************************************
// Operation
// - align hold time from 4-bit code
// - align current limit 0.1 V steps
// - probe pulse rate from 3-bit code
// - probe current limit from 4-bit code
// - release windings by brake or tristate
// - lead angle 0, 30, 60 or 90 degrees
// - repeat probe up to four times, average
// - first electrical cycle rate from code
// - start-up method selects used fields
// ****************************************************************
package startup_cfg_pkg;

    localparam logic [7:0] SPIN_UP_A_OFFSET = 8'h82;
    localparam logic [7:0] STATUS_OFFSET = 8'h83;
    localparam logic [31:0] SPIN_UP_A_RESET = 32'h0000_0000;

    // field positions (low bit)
    localparam int PARITY_POS = 31;
    localparam int METHOD_POS = 29;
    localparam int ALIGN_TIME_POS = 21;
    localparam int ALIGN_LIM_POS = 17;
    localparam int PROBE_RATE_POS = 14;
    localparam int PROBE_LIM_POS = 10;
    localparam int RELEASE_POS = 8;
    localparam int LEAD_POS = 6;
    localparam int REPEAT_POS = 4;
    localparam int FIRST_RATE_POS = 0;

    localparam int unsigned CLK_HZ_DEFAULT = 125_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned CHZ_PER_HZ = 100;
    localparam int unsigned STEPS_PER_CYCLE = 6;
    localparam int unsigned DEG_PER_LEAD_CODE = 30;

    // align time in ms
    localparam int unsigned ALIGN_MS [16] = '{5, 10, 25, 50, 75, 100, 200, 400,
        600, 800, 1000, 2000, 4000, 6000, 8000, 10000};
    // probe pulse rate in Hz
    localparam int unsigned PROBE_HZ [8] = '{50, 100, 250, 500, 1000, 2000, 5000, 10000};
    // first cycle rate in hundredths of Hz; code a is unlisted and takes 15 Hz
    localparam int unsigned FIRST_CHZ [16] = '{5, 10, 25, 50, 100, 200, 300, 500,
        1000, 1500, 1500, 2500, 5000, 10000, 15000, 20000};

    typedef enum logic [1:0] {
        M_ALIGN = 2'b00,
        M_DOUBLE_ALIGN = 2'b01,
        M_PROBE = 2'b10,
        M_SLOW_FIRST = 2'b11
    } method_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ALIGN = 3'b001,
        S_ALIGN2 = 3'b010,
        S_PROBE = 3'b011,
        S_SLOW = 3'b100,
        S_DONE = 3'b101
    } seq_e;

endpackage

// ==== hw/interval_if.sv ====
// carrier between the sequencer and its interval timer
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface interval_if;
    logic load;
    logic run;
    logic [31:0] period;
    logic tick;
    modport ctrl (output load, output run, output period, input tick);
    modport timer (input load, input run, input period, output tick);
endinterface
`default_nettype wire

// ==== hw/interval_timer.sv ====
// reloadable interval timer: ticks once every period cycles while running
// assumes period is at least one; zero is treated as one
`timescale 1ns/1ps
`default_nettype none
module interval_timer (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control
    interval_if.timer tmr
);
    logic [31:0] count_q;
    logic [31:0] count_d;
    logic [31:0] reload;

    always_comb begin
        reload = (tmr.period == 32'h0000_0000) ? 32'h0000_0000 : tmr.period - 32'h0000_0001;
        // tick must not look at load: the sequencer raises load on a tick,
        // and reading it back here would close a combinational loop
        tmr.tick = tmr.run && (count_q == 32'h0000_0000);
        count_d = count_q;
        if (tmr.load) begin
            count_d = reload;
        end else if (tmr.run) begin
            count_d = (count_q == 32'h0000_0000) ? reload : count_q - 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= 32'h0000_0000;
        end else begin
            count_q <= count_d;
        end
    end
endmodule
`default_nettype wire

// ==== hw/motor_startup_align_probe_config.sv ====
// start-up configuration register and the start-up sequencer it steers
// assumes start and probe_sample come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module motor_startup_align_probe_config #(
    parameter int unsigned CLK_HZ = startup_cfg_pkg::CLK_HZ_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // sequence control
    input wire logic start,
    input wire logic [7:0] probe_sample,
    // sequence outputs
    output startup_cfg_pkg::seq_e seq_state,
    output logic align_active,
    output logic probe_pulse,
    output logic [2:0] commutation_step,
    output logic release_brake,
    output logic release_tristate,
    output logic [7:0] probe_average,
    // decoded limits and angle
    output logic [3:0] align_current_limit_code,
    output logic [3:0] rotor_probe_current_limit,
    output logic [6:0] rotor_probe_lead_angle
);
    import startup_cfg_pkg::*;

    // ****************************************************************
    // configuration register
    // ****************************************************************
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic [1:0] startup_method_select;
    logic [3:0] align_time_code;
    logic [2:0] rotor_probe_pulse_rate;
    logic [1:0] rotor_probe_release_style;
    logic [1:0] rotor_probe_repeat_count;
    logic [3:0] first_cycle_rate;

    assign startup_method_select = cfg_q[METHOD_POS +: 2];
    assign align_time_code = cfg_q[ALIGN_TIME_POS +: 4];
    assign rotor_probe_pulse_rate = cfg_q[PROBE_RATE_POS +: 3];
    assign rotor_probe_release_style = cfg_q[RELEASE_POS +: 2];
    assign rotor_probe_repeat_count = cfg_q[REPEAT_POS +: 2];
    assign first_cycle_rate = cfg_q[FIRST_RATE_POS +: 4];

    always_comb begin
        cfg_d = cfg_q;
        if (reg_wr && reg_addr == SPIN_UP_A_OFFSET) begin
            cfg_d = reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= SPIN_UP_A_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ****************************************************************
    // interval lengths in clock cycles
    // ****************************************************************
    logic [31:0] align_cycles;
    logic [31:0] probe_cycles;
    logic [31:0] slow_step_cycles;
    logic [63:0] slow_num;
    logic [63:0] slow_den;
    logic [63:0] slow_quot;

    always_comb begin
        align_cycles = 32'((64'(CLK_HZ) * 64'(ALIGN_MS[align_time_code])) / 64'(MS_PER_S));
        probe_cycles = CLK_HZ / PROBE_HZ[rotor_probe_pulse_rate];
        // one electrical cycle is six commutation steps
        slow_num = 64'(CLK_HZ) * 64'(CHZ_PER_HZ);
        slow_den = 64'(FIRST_CHZ[first_cycle_rate]) * 64'(STEPS_PER_CYCLE);
        slow_quot = slow_num / slow_den;
        slow_step_cycles = slow_quot[31:0];
    end

    // ****************************************************************
    // start-up sequencer
    // ****************************************************************
    interval_if tif ();

    interval_timer u_timer (
        .clk(clk),
        .arst_n(arst_n),
        .tmr(tif.timer)
    );

    seq_e state_q;
    seq_e state_d;
    method_e method_q;
    method_e method_d;
    logic [2:0] step_q;
    logic [2:0] step_d;
    logic [1:0] round_q;
    logic [1:0] round_d;
    logic [9:0] sum_q;
    logic [9:0] sum_d;
    logic [7:0] avg_q;
    logic [7:0] avg_d;
    logic [9:0] sum_next;
    logic [9:0] avg_wide;

    always_comb begin
        state_d = state_q;
        method_d = method_q;
        step_d = step_q;
        round_d = round_q;
        sum_d = sum_q;
        avg_d = avg_q;
        tif.load = 1'b0;
        tif.period = align_cycles;
        sum_next = sum_q + {2'b00, probe_sample};
        avg_wide = sum_next / (10'(rotor_probe_repeat_count) + 10'h001);
        case (state_q)
            S_IDLE: begin
                if (start) begin
                    method_d = method_e'(startup_method_select);
                    step_d = 3'h0;
                    round_d = 2'h0;
                    sum_d = 10'h000;
                    tif.load = 1'b1;
                    case (method_e'(startup_method_select))
                        M_ALIGN, M_DOUBLE_ALIGN: begin
                            state_d = S_ALIGN;
                            tif.period = align_cycles;
                        end
                        M_PROBE: begin
                            state_d = S_PROBE;
                            tif.period = probe_cycles;
                        end
                        default: begin
                            state_d = S_SLOW;
                            tif.period = slow_step_cycles;
                        end
                    endcase
                end
            end
            S_ALIGN: begin
                if (tif.tick) begin
                    if (method_q == M_DOUBLE_ALIGN) begin
                        state_d = S_ALIGN2;
                        tif.load = 1'b1;
                    end else begin
                        state_d = S_DONE;
                    end
                end
            end
            S_ALIGN2: begin
                if (tif.tick) begin
                    state_d = S_DONE;
                end
            end
            S_PROBE: begin
                tif.period = probe_cycles;
                if (tif.tick) begin
                    step_d = step_q + 3'h1;
                    if (step_q == 3'h5) begin
                        // each round probes all six sectors, then one sample is summed
                        step_d = 3'h0;
                        sum_d = sum_next;
                        round_d = round_q + 2'h1;
                        if (round_q == rotor_probe_repeat_count) begin
                            avg_d = avg_wide[7:0];
                            state_d = S_DONE;
                        end
                    end
                end
            end
            S_SLOW: begin
                tif.period = slow_step_cycles;
                if (tif.tick) begin
                    step_d = step_q + 3'h1;
                    if (step_q == 3'h5) begin
                        step_d = 3'h0;
                        state_d = S_DONE;
                    end
                end
            end
            S_DONE: begin
                // stays until start is dropped, so one request gives one sequence
                if (!start) begin
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    assign tif.run = (state_q == S_ALIGN) || (state_q == S_ALIGN2) ||
        (state_q == S_PROBE) || (state_q == S_SLOW);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= S_IDLE;
            method_q <= M_ALIGN;
            step_q <= 3'h0;
            round_q <= 2'h0;
            sum_q <= 10'h000;
            avg_q <= 8'h00;
        end else begin
            state_q <= state_d;
            method_q <= method_d;
            step_q <= step_d;
            round_q <= round_d;
            sum_q <= sum_d;
            avg_q <= avg_d;
        end
    end

    // ****************************************************************
    // registered limits, angle and release flags, then the combinational read mux and output assigns
    // ****************************************************************
    logic [3:0] align_lim_q;
    logic [3:0] align_lim_d;
    logic [3:0] probe_lim_q;
    logic [3:0] probe_lim_d;
    logic [6:0] lead_q;
    logic [6:0] lead_d;
    logic brake_q;
    logic brake_d;
    logic tristate_q;
    logic tristate_d;
    logic probe_done;

    always_comb begin
        align_lim_d = cfg_q[ALIGN_LIM_POS +: 4];
        if (align_lim_d == 4'h0) begin
            align_lim_d = 4'h1;
        end
        probe_lim_d = cfg_q[PROBE_LIM_POS +: 4];
        if (probe_lim_d == 4'h0) begin
            probe_lim_d = 4'h1;
        end
        lead_d = 7'(cfg_q[LEAD_POS +: 2] * DEG_PER_LEAD_CODE);
        probe_done = (state_q == S_DONE) && (method_q == M_PROBE);
        brake_d = probe_done && (rotor_probe_release_style == 2'h0);
        tristate_d = probe_done && (rotor_probe_release_style != 2'h0);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            align_lim_q <= 4'h1;
            probe_lim_q <= 4'h1;
            lead_q <= 7'h00;
            brake_q <= 1'b0;
            tristate_q <= 1'b0;
        end else begin
            align_lim_q <= align_lim_d;
            probe_lim_q <= probe_lim_d;
            lead_q <= lead_d;
            brake_q <= brake_d;
            tristate_q <= tristate_d;
        end
    end

    always_comb begin
        if (reg_addr == SPIN_UP_A_OFFSET) begin
            reg_rdata = cfg_q;
        end else if (reg_addr == STATUS_OFFSET) begin
            reg_rdata = {13'h0000, state_q, step_q, round_q, 3'h0, avg_q};
        end else begin
            reg_rdata = 32'h0000_0000;
        end
    end

    assign seq_state = state_q;
    assign align_active = (state_q == S_ALIGN) || (state_q == S_ALIGN2);
    assign probe_pulse = (state_q == S_PROBE) && tif.tick;
    assign commutation_step = step_q;
    assign release_brake = brake_q;
    assign release_tristate = tristate_q;
    assign probe_average = avg_q;
    assign align_current_limit_code = align_lim_q;
    assign rotor_probe_current_limit = probe_lim_q;
    assign rotor_probe_lead_angle = lead_q;
endmodule
`default_nettype wire

// ==== bench/startup_cfg_sva.sv ====
// port-level checker for the start-up configuration block
// assumes it is bound to the block's top module on its only clock
`timescale 1ns/1ps
`default_nettype none
module startup_cfg_sva (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    // sequence
    input wire logic start,
    input wire startup_cfg_pkg::seq_e seq_state,
    input wire logic align_active,
    input wire logic probe_pulse,
    input wire logic [2:0] commutation_step,
    input wire logic release_brake,
    input wire logic release_tristate,
    // decoded values
    input wire logic [3:0] align_current_limit_code,
    input wire logic [3:0] rotor_probe_current_limit,
    input wire logic [6:0] rotor_probe_lead_angle
);
    import startup_cfg_pkg::*;
    // ****************************************
    // shadow of the word, one cycle behind for decoded outputs
    // ****************************************
    logic [31:0] word_q, word_d, dec_q;
    always_comb begin
        word_d = word_q;
        if (reg_wr && reg_addr == SPIN_UP_A_OFFSET) begin
            word_d = reg_wdata;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            word_q <= SPIN_UP_A_RESET;
            dec_q <= SPIN_UP_A_RESET;
        end else begin
            word_q <= word_d;
            dec_q <= word_q;
        end
    end
    function automatic logic [3:0] lim(input logic [3:0] c);
        return (c == 4'h0) ? 4'h1 : c;
    endfunction
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_align_flag: assert property (align_active == (seq_state inside {S_ALIGN, S_ALIGN2}))
        else $error("align flag wrong");
    a_method_pick: assert property ((seq_state == S_IDLE && start) |=>
        (seq_state == S_PROBE) == ($past(word_q[30:29]) == 2'h2)) else $error("bad method");
    a_done_hold: assert property ((seq_state == S_DONE && start) |=> seq_state == S_DONE)
        else $error("done not held");
    a_done_idle: assert property ((seq_state == S_DONE && !start) |=> seq_state == S_IDLE)
        else $error("no return to idle");
    a_brake_code: assert property (release_brake |-> dec_q[9:8] == 2'h0)
        else $error("brake with wrong code");
    a_tristate_code: assert property (release_tristate |-> dec_q[9:8] != 2'h0)
        else $error("tristate with wrong code");
    a_step_range: assert property (commutation_step <= 3'h5)
        else $error("step out of range");
    a_lead_angle: assert property (rotor_probe_lead_angle == 7'(30 * dec_q[7:6]))
        else $error("lead angle wrong");
    a_align_limit: assert property (align_current_limit_code == lim(dec_q[20:17]))
        else $error("align limit wrong");
    a_probe_limit: assert property (rotor_probe_current_limit == lim(dec_q[13:10]))
        else $error("probe limit wrong");
    a_read_word: assert property (reg_addr == SPIN_UP_A_OFFSET |-> reg_rdata == word_q)
        else $error("readback wrong");
    a_pulse_single: assert property (probe_pulse |=> !probe_pulse)
        else $error("pulse too long");
endmodule
bind motor_startup_align_probe_config startup_cfg_sva u_startup_cfg_sva (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .start(start), .seq_state(seq_state),
    .align_active(align_active), .probe_pulse(probe_pulse),
    .commutation_step(commutation_step), .release_brake(release_brake),
    .release_tristate(release_tristate), .align_current_limit_code(align_current_limit_code),
    .rotor_probe_current_limit(rotor_probe_current_limit),
    .rotor_probe_lead_angle(rotor_probe_lead_angle));
`default_nettype wire

// ==== bench/motor_startup_align_probe_config_test.sv ====
// self-checking bench for the start-up configuration block
// assumes a scaled clock rate so every start-up run stays short
`timescale 1ns/1ps
`default_nettype none
module motor_startup_align_probe_config_test;
    import startup_cfg_pkg::*;
    localparam int unsigned HZ = 100_000;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic start = 1'b0;
    logic [7:0] probe_sample = 8'h3c;
    logic [31:0] reg_rdata, rd, w;
    seq_e seq_state;
    logic align_active, probe_pulse, release_brake, release_tristate;
    logic [2:0] commutation_step;
    logic [7:0] probe_average;
    logic [3:0] align_current_limit_code, rotor_probe_current_limit, c;
    logic [6:0] rotor_probe_lead_angle;
    int fails = 0;
    int check_count = 0;
    int cyc, pulses, act;
    int slow_code[3] = '{15, 14, 10};
    int slow_cyc[3] = '{500, 666, 6666};
    always #4 clk = ~clk;
    motor_startup_align_probe_config #(.CLK_HZ(HZ)) u_motor_startup_align_probe_config (
        .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .start(start),
        .probe_sample(probe_sample), .seq_state(seq_state), .align_active(align_active),
        .probe_pulse(probe_pulse), .commutation_step(commutation_step),
        .release_brake(release_brake), .release_tristate(release_tristate),
        .probe_average(probe_average), .align_current_limit_code(align_current_limit_code),
        .rotor_probe_current_limit(rotor_probe_current_limit),
        .rotor_probe_lead_angle(rotor_probe_lead_angle));
    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_near(input int got, input int exp, input int tol, input string what);
        check_count++;
        if (got < exp - tol || got > exp + tol) begin
            fails++;
            $display("Error at %0t: %s took %0d expected %0d", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        #1;
        d = reg_rdata;
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // start is held through the run; only probe-state pulses are counted
    task automatic run(input logic [31:0] word);
        wr(SPIN_UP_A_OFFSET, word);
        @(posedge clk);
        start <= 1'b1;
        cyc = 0;
        pulses = 0;
        act = 0;
        @(posedge clk);
        #1;
        while (seq_state !== S_DONE && cyc < 20000) begin
            @(posedge clk);
            #1;
            cyc++;
            if (probe_pulse === 1'b1 && seq_state === S_PROBE) pulses++;
            if (align_active === 1'b1) act++;
        end
        settle();
    endtask
    task automatic stop;
        @(posedge clk);
        start <= 1'b0;
        settle();
        chk({29'h0, seq_state}, 32'h0, "idle after run");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rd_reg(SPIN_UP_A_OFFSET, rd);
        chk(rd, 32'h0, "reset word");
        chk({28'h0, align_current_limit_code}, 32'h1, "reset limit");
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            w = {11'h0, c, 3'h0, c, 2'h0, c[1:0], 6'h0};
            wr(SPIN_UP_A_OFFSET, w);
            settle();
            chk({28'h0, align_current_limit_code}, (i == 0) ? 1 : i, "align lim");
            chk({28'h0, rotor_probe_current_limit}, (i == 0) ? 1 : i, "probe lim");
            chk({25'h0, rotor_probe_lead_angle}, 32'(30 * (i % 4)), "lead");
        end
        wr(8'h84, 32'hffff_ffff);
        rd_reg(SPIN_UP_A_OFFSET, rd);
        chk(rd, w, "word after stray write");
        rd_reg(8'h84, rd);
        chk(rd, 32'h0, "unmapped read");
        $display("test decode done");
        for (int m = 0; m < 2; m++) begin
            for (int a = 0; a < 2; a++) begin
                run({1'b0, 2'(m), 4'h0, 4'(a), 21'h0});
                chk_near(cyc, 100 * (a ? 10 : 5) * (m + 1), 3, "align run");
                chk_near(act, 100 * (a ? 10 : 5) * (m + 1), 3, "align active");
                stop();
            end
        end
        $display("test align done");
        // reset in the middle of an align run must drop the word and the sequence
        wr(SPIN_UP_A_OFFSET, {3'h0, 4'h0, 4'h3, 21'h0});
        @(posedge clk);
        start <= 1'b1;
        repeat (20) @(posedge clk);
        arst_n <= 1'b0;
        start <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        settle();
        rd_reg(SPIN_UP_A_OFFSET, rd);
        chk(rd, 32'h0, "word after reset");
        chk({29'h0, seq_state}, 32'h0, "idle after reset");
        chk({28'h0, align_current_limit_code}, 32'h1, "limit after reset");
        $display("test reset in run done");
        // slower rate on odd passes so the paced interval is seen to change
        for (int r = 0; r < 4; r++) begin
            run({1'b0, 2'h2, 12'h0, 3'((r % 2) ? 6 : 7), 4'h0, 2'(r), 2'h0, 2'(r), 4'h0});
            chk(pulses, 6 * (r + 1), "probe pulses");
            chk_near(cyc, 6 * (r + 1) * ((r % 2) ? 20 : 10), 4, "probe run");
            chk({30'h0, release_tristate, release_brake}, (r > 0) + 1, "release");
            chk({24'h0, probe_average}, 32'h3c, "average");
            rd_reg(STATUS_OFFSET, rd);
            chk({rd[18:16], rd[7:0]}, {3'h5, 8'h3c}, "status");
            stop();
        end
        $display("test probe done");
        for (int s = 0; s < 3; s++) begin
            run({1'b0, 2'h3, 25'h0, 4'(slow_code[s])});
            chk_near(cyc, slow_cyc[s], 8, "slow cycle");
            stop();
        end
        $display("test slow done");
        conclude();
    end
    initial begin
        #400000;
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
`default_nettype wire
